// ### rcr_pkg.sv
// package: register map, field layout, reset values and timing counts
package rcr_pkg;
   // ----------------------------------------
   // command word layout
   // ----------------------------------------
   localparam int          CMD_CODE_HI  = 15;
   localparam int          CMD_CODE_LO  = 12;
   localparam int          CMD_ADDR_HI  = 11;
   localparam int          CMD_ADDR_LO  = 8;
   localparam logic [3:0]  CODE_WRITE   = 4'h1;
   localparam logic [3:0]  CODE_READ    = 4'h2;
   localparam logic [3:0]  CODE_RESET   = 4'h3;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [3:0]  ADDR_CONFIG  = 4'h1;
   localparam logic [3:0]  ADDR_CONTROL = 4'h2;
   localparam logic [3:0]  ADDR_STATUS  = 4'h9;
   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   localparam int          CFG_GAIN     = 6;
   localparam int          CFG_LONGCAL  = 5;
   localparam int          CFG_FPIN     = 4;
   localparam int          CFG_APIN     = 3;
   localparam int          CFG_PS_HI    = 2;
   localparam int          CFG_PS_LO    = 1;
   localparam int          CFG_DRX      = 0;
   localparam logic [7:0]  CFG_RESET    = 8'h40;
   // ----------------------------------------
   // control and status fields
   // ----------------------------------------
   localparam int          CTL_HOLD     = 6;
   localparam int          CTL_FTRK     = 3;
   localparam int          CTL_ATRK     = 2;
   localparam int          CTL_POLCAL   = 1;
   localparam int          CTL_FCAL     = 0;
   localparam logic [7:0]  CTL_RESET    = 8'h00;
   localparam int          STS_POLDONE  = 1;
   localparam int          STS_FDONE    = 0;
   // ----------------------------------------
   // calibration timing
   // ----------------------------------------
   localparam int          CLK_NS       = 8;
   localparam int          CAL_SHORT_US = 100;
   localparam int          CAL_LONG_US  = 1000;
   localparam int          CAL_POLL_US  = 500;
   localparam int          CAL_SHORT_CY = (CAL_SHORT_US * 1000) / CLK_NS;
   localparam int          CAL_LONG_CY  = (CAL_LONG_US * 1000) / CLK_NS;
   localparam int          CAL_POLL_CY  = (CAL_POLL_US * 1000) / CLK_NS;
endpackage

// ### rcr_cal_timer.sv
// calibration run timer: counts a load value down and pulses done
`timescale 1ns/1ps
module rcr_cal_timer #(
   parameter int WIDTH = 20
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] length,
   output logic                  busy,
   output logic                  done
);
   logic [WIDTH-1:0] count;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         // done blocks a restart while the start bit is still being cleared
         if (start && !busy && !done)
         begin
            count <= length;
            busy  <= 1'b1;
         end
         else if (busy)
         begin
            if (count <= 1)
            begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            else
               count <= count - 1'b1;
         end
      end
   end
endmodule // rcr_cal_timer

// ### rcr_regs.sv
// receiver configuration and control registers behind the serial interface
// Operation
// - command 0x3000 resets every register; host sends it first.
// - host reads 0x2900 until status bit 0 is one.
// - configuration bit 6 selects LNA gain, high after reset.
// - configuration bit 5 selects long precise calibration, reset zero.
// - configuration bit 4 routes read data onto frequency data pin.
// - configuration bit 3 routes read data onto amplitude data pin.
// - configuration bits 2:1 choose off-timer step size, reset zero.
// - configuration bit 0 selects discontinuous receive, reset zero.
// - configuration bit 0 clear means continuous receive.
// - control bit 6 freezes LNA gain state, reset zero.
// - control bit 3 enables frequency peak tracking, reset zero.
// - control bit 2 enables amplitude peak tracking, reset zero.
// - control bit 1 starts poll timer calibration, self clears.
// - control bit 0 starts frequency calibration, self clears.
// - status bit 0 is zero while calibrating, one when done.
`timescale 1ns/1ps
module rcr_regs #(
   parameter int CAL_SHORT_CY = rcr_pkg::CAL_SHORT_CY,
   parameter int CAL_LONG_CY  = rcr_pkg::CAL_LONG_CY,
   parameter int CAL_POLL_CY  = rcr_pkg::CAL_POLL_CY
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic sclk_pin,
   input  wire logic sdi_pin,
   input  wire logic cs_n_pin,
   output logic      sdo,
   output logic      sdo_oe,
   output logic      freq_data_pin,
   output logic      ampl_data_pin,
   input  wire logic freq_data_rx,
   input  wire logic ampl_data_rx,
   output logic      lna_gain_select,
   output logic      long_cal_select,
   output logic      off_timer_prescale_hi,
   output logic      off_timer_prescale_lo,
   output logic      discontinuous_rx_select,
   output logic      continuous_rx,
   output logic      gain_hold,
   output logic      freq_peak_track_enable,
   output logic      ampl_peak_track_enable,
   output logic      freq_cal_running,
   output logic      poll_cal_running,
   output logic      freq_cal_complete_flag
);
   // ----------------------------------------
   // pin synchronisers and edge finding
   // ----------------------------------------
   logic [1:0] sclk_s;
   logic [1:0] sdi_s;
   logic [1:0] cs_s;
   logic       sclk_d;
   logic       cs_d;
   wire        sclk_rise = sclk_s[1] & ~sclk_d;
   wire        sclk_fall = ~sclk_s[1] & sclk_d;
   wire        cs_rise   = cs_s[1] & ~cs_d;
   wire        sel       = ~cs_s[1];

   // ----------------------------------------
   // word shift and decode
   // ----------------------------------------
   logic [15:0] shift;
   logic [4:0]  nbits;
   logic [7:0]  cfg;
   logic [7:0]  ctl;
   logic [7:0]  rd_word;
   logic        poll_done;
   logic        fdone;
   wire  [15:0] word      = shift;
   wire  [3:0]  code      = word[rcr_pkg::CMD_CODE_HI:rcr_pkg::CMD_CODE_LO];
   wire  [3:0]  addr      = word[rcr_pkg::CMD_ADDR_HI:rcr_pkg::CMD_ADDR_LO];
   wire         word_end  = cs_rise && (nbits == 5'd16);
   wire         is_reset  = word_end && code == rcr_pkg::CODE_RESET;
   wire         is_write  = word_end && code == rcr_pkg::CODE_WRITE;
   wire         is_read8  = sel && sclk_rise && nbits == 5'd7
                            && shift[6:3] == rcr_pkg::CODE_READ;
   wire  [3:0]  rd_addr   = {shift[2:0], sdi_s[1]};
   wire         wr_cfg    = is_write && addr == rcr_pkg::ADDR_CONFIG;
   wire         wr_ctl    = is_write && addr == rcr_pkg::ADDR_CONTROL;
   wire  [7:0]  status    = {6'h00, poll_done, fdone};
   wire  [7:0]  rd_sel    = (rd_addr == rcr_pkg::ADDR_CONFIG)  ? {1'b0, cfg[6:0]} :
                            (rd_addr == rcr_pkg::ADDR_CONTROL) ? {1'b0, ctl[6], 2'b00,
                                                                  ctl[3:0]} :
                            (rd_addr == rcr_pkg::ADDR_STATUS)  ? status : 8'h00;

   // ----------------------------------------
   // calibration engines
   // ----------------------------------------
   logic fcal_busy;
   logic fcal_done;
   logic pcal_busy;
   logic pcal_done;
   wire  [19:0] fcal_len = cfg[rcr_pkg::CFG_LONGCAL] ? 20'(CAL_LONG_CY)
                                                     : 20'(CAL_SHORT_CY);
   rcr_cal_timer #(.WIDTH(20)) u_fcal (
      .clk    (clk),
      .srst   (srst | is_reset),
      .start  (ctl[rcr_pkg::CTL_FCAL]),
      .length (fcal_len),
      .busy   (fcal_busy),
      .done   (fcal_done)
   );
   rcr_cal_timer #(.WIDTH(20)) u_pcal (
      .clk    (clk),
      .srst   (srst | is_reset),
      .start  (ctl[rcr_pkg::CTL_POLCAL]),
      .length (20'(CAL_POLL_CY)),
      .busy   (pcal_busy),
      .done   (pcal_done)
   );

   // ----------------------------------------
   // serial front end
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sclk_s <= 2'b00;
         sdi_s  <= 2'b00;
         cs_s   <= 2'b11;
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
         shift  <= 16'h0000;
         nbits  <= 5'd0;
      end
      else
      begin
         sclk_s <= {sclk_s[0], sclk_pin};
         sdi_s  <= {sdi_s[0], sdi_pin};
         cs_s   <= {cs_s[0], cs_n_pin};
         sclk_d <= sclk_s[1];
         cs_d   <= cs_s[1];
         if (!sel)
            nbits <= 5'd0;
         else if (sclk_rise && nbits != 5'd16)
         begin
            shift <= {shift[14:0], sdi_s[1]};
            nbits <= nbits + 5'd1;
         end
      end
   end

   // ----------------------------------------
   // read data out: msb first on falling sclk
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_word <= 8'h00;
         sdo     <= 1'b0;
         sdo_oe  <= 1'b0;
      end
      else if (is_read8)
      begin
         rd_word <= rd_sel;
         sdo_oe  <= 1'b1;
      end
      else if (!sel)
         sdo_oe <= 1'b0;
      else if (sclk_fall && sdo_oe)
      begin
         sdo     <= rd_word[7];
         rd_word <= {rd_word[6:0], 1'b0};
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst || is_reset)
      begin
         cfg       <= rcr_pkg::CFG_RESET;
         ctl       <= rcr_pkg::CTL_RESET;
         fdone     <= 1'b0;
         poll_done <= 1'b0;
      end
      else
      begin
         if (wr_cfg)
            cfg <= word[7:0];
         if (wr_ctl)
            ctl <= word[7:0];
         else
         begin
            if (fcal_done)
               ctl[rcr_pkg::CTL_FCAL] <= 1'b0;
            if (pcal_done)
               ctl[rcr_pkg::CTL_POLCAL] <= 1'b0;
         end
         if (wr_ctl && word[rcr_pkg::CTL_FCAL])
            fdone <= 1'b0;
         else if (fcal_done)
            fdone <= 1'b1;
         if (wr_ctl && word[rcr_pkg::CTL_POLCAL])
            poll_done <= 1'b0;
         else if (pcal_done)
            poll_done <= 1'b1;
      end
   end

   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         freq_data_pin           <= 1'b0;
         ampl_data_pin           <= 1'b0;
         lna_gain_select         <= 1'b1;
         long_cal_select         <= 1'b0;
         off_timer_prescale_hi   <= 1'b0;
         off_timer_prescale_lo   <= 1'b0;
         discontinuous_rx_select <= 1'b0;
         continuous_rx           <= 1'b1;
         gain_hold               <= 1'b0;
         freq_peak_track_enable  <= 1'b0;
         ampl_peak_track_enable  <= 1'b0;
         freq_cal_running        <= 1'b0;
         poll_cal_running        <= 1'b0;
         freq_cal_complete_flag  <= 1'b0;
      end
      else
      begin
         freq_data_pin           <= cfg[rcr_pkg::CFG_FPIN] ? sdo : freq_data_rx;
         ampl_data_pin           <= cfg[rcr_pkg::CFG_APIN] ? sdo : ampl_data_rx;
         lna_gain_select         <= cfg[rcr_pkg::CFG_GAIN];
         long_cal_select         <= cfg[rcr_pkg::CFG_LONGCAL];
         off_timer_prescale_hi   <= cfg[rcr_pkg::CFG_PS_HI];
         off_timer_prescale_lo   <= cfg[rcr_pkg::CFG_PS_LO];
         discontinuous_rx_select <= cfg[rcr_pkg::CFG_DRX];
         continuous_rx           <= ~cfg[rcr_pkg::CFG_DRX];
         gain_hold               <= ctl[rcr_pkg::CTL_HOLD];
         freq_peak_track_enable  <= ctl[rcr_pkg::CTL_FTRK];
         ampl_peak_track_enable  <= ctl[rcr_pkg::CTL_ATRK];
         freq_cal_running        <= fcal_busy;
         poll_cal_running        <= pcal_busy;
         freq_cal_complete_flag  <= fdone;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_reset_cmd;
      @(posedge clk) disable iff (srst) is_reset |=> cfg == 8'h40 && ctl == 8'h00;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");
   property p_gain;
      @(posedge clk) disable iff (srst) 1 |=> lna_gain_select == $past(cfg[6]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain output wrong");
   property p_cont;
      @(posedge clk) disable iff (srst) 1 |=> continuous_rx == !$past(cfg[0])
         && continuous_rx != discontinuous_rx_select;
   endproperty
   a_cont: assert property (p_cont) else $error("receive mode outputs disagree");
   property p_drx;
      @(posedge clk) disable iff (srst)
         wr_cfg |=> ##1 discontinuous_rx_select == $past(word[0], 2);
   endproperty
   a_drx: assert property (p_drx) else $error("receive mode not taken");
   property p_fcal_clear;
      @(posedge clk) disable iff (srst) fcal_done && !wr_ctl && !is_reset |=> !ctl[0];
   endproperty
   a_fcal_clear: assert property (p_fcal_clear) else $error("start bit not cleared");
   property p_pcal_clear;
      @(posedge clk) disable iff (srst) pcal_done && !wr_ctl && !is_reset |=> !ctl[1];
   endproperty
   a_pcal_clear: assert property (p_pcal_clear) else $error("poll start bit stuck");
   property p_done_low;
      @(posedge clk) disable iff (srst) fcal_busy |-> !fdone;
   endproperty
   a_done_low: assert property (p_done_low) else $error("done while calibrating");
   property p_track;
      @(posedge clk) disable iff (srst)
         wr_ctl |=> ##1 freq_peak_track_enable == $past(word[3], 2)
                     && ampl_peak_track_enable == $past(word[2], 2);
   endproperty
   a_track: assert property (p_track) else $error("tracking enables not taken");
   property p_hold;
      @(posedge clk) disable iff (srst) wr_ctl |=> ##1 gain_hold == $past(word[6], 2);
   endproperty
   a_hold: assert property (p_hold) else $error("gain hold not taken");
endmodule // rcr_regs

// ### rcr_host_model.sv
// host model: drives command frames on the serial interface
`timescale 1ns/1ps
module rcr_host_model (
   output logic      sclk_pin,
   output logic      sdi_pin,
   output logic      cs_n_pin,
   input  wire logic sdo_line
);
   // ----------------------------------------
   // one 16-bit frame, msb first
   // ----------------------------------------
   task automatic xfer(input logic [15:0] word, output logic [7:0] rdata);
      int i;
      rdata = 8'h00;
      cs_n_pin = 1'b0;
      for (i = 15; i >= 0; i--)
      begin
         sdi_pin = word[i];
         #62.5 sclk_pin = 1'b1;
         if (i < 8) rdata[i] = sdo_line;
         #62.5 sclk_pin = 1'b0;
      end
      // released data line shows the inverse of its last bit
      sdi_pin = ~word[0];
      #62.5 cs_n_pin = 1'b1;
      #250;
   endtask

   initial
   begin
      sclk_pin = 1'b0;
      sdi_pin = 1'b0;
      cs_n_pin = 1'b1;
   end
endmodule // rcr_host_model

// ### tb_rcr_regs.sv
// testbench: serial register access, fields, calibration and pin routing
`timescale 1ns/1ps
module tb_rcr_regs;
   localparam int SHORT_CY = 200;
   localparam int LONG_CY  = 400;
   localparam int POLL_CY  = 300;
   logic clk, srst, freq_data_rx, ampl_data_rx, sclk_pin, sdi_pin, cs_n_pin;
   logic sdo, sdo_oe, freq_data_pin, ampl_data_pin, sdo_line;
   logic gain, lcal, ps_hi, ps_lo, drx, cont, hold, ftrk, atrk, fcr, pcr, fdone;
   logic [1:0] pin_sel;
   logic [7:0] rd;
   int         n_fail, total_checks, run_cy, oe_cy;

   rcr_regs #(.CAL_SHORT_CY(SHORT_CY), .CAL_LONG_CY(LONG_CY), .CAL_POLL_CY(POLL_CY)) dut (
      .clk(clk), .srst(srst), .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
      .cs_n_pin(cs_n_pin), .sdo(sdo), .sdo_oe(sdo_oe), .freq_data_pin(freq_data_pin),
      .ampl_data_pin(ampl_data_pin), .freq_data_rx(freq_data_rx),
      .ampl_data_rx(ampl_data_rx), .lna_gain_select(gain), .long_cal_select(lcal),
      .off_timer_prescale_hi(ps_hi), .off_timer_prescale_lo(ps_lo),
      .discontinuous_rx_select(drx), .continuous_rx(cont), .gain_hold(hold),
      .freq_peak_track_enable(ftrk), .ampl_peak_track_enable(atrk),
      .freq_cal_running(fcr), .poll_cal_running(pcr), .freq_cal_complete_flag(fdone));

   assign sdo_line = (pin_sel == 2'd1) ? freq_data_pin :
                     (pin_sel == 2'd2) ? ampl_data_pin : sdo;

   rcr_host_model host (.sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .cs_n_pin(cs_n_pin),
                        .sdo_line(sdo_line));

   // ----------------------------------------
   // clock, cycle count and helpers
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (fcr === 1'b1 || pcr === 1'b1) run_cy++;
      if (sdo_oe === 1'b1) oe_cy++;
   end

   task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [8:0] exp_outs(input logic [7:0] c, input logic [7:0] t);
      return {c[6], c[5], c[2], c[1], c[0], ~c[0], t[6], t[3], t[2]};
   endfunction

   task automatic cmd(input logic [15:0] w);
      @(posedge clk) #1;
      host.xfer(w, rd);
   endtask

   task automatic wait_cal(input int lim);
      int n;
      n = 0;
      while ((fcr | pcr) === 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      check("cal limit", n < lim, 1'b1);
      repeat (4) @(posedge clk);
   endtask

   task automatic stop_test();
      if (n_fail == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      check("outs", {gain, lcal, ps_hi, ps_lo, drx, cont, hold, ftrk, atrk},
            exp_outs(8'h40, 8'h00));
      oe_cy = 0;
      cmd(16'h2100);
      check("cfg", rd & 8'h7F, 8'h40);
      check("oe read", oe_cy != 0, 1'b1);
      check("oe idle", sdo_oe, 1'b0);
      cmd(16'h2200);
      check("ctl", rd & 8'h4F, 8'h00);
      cmd(16'h4100);
      check("bad code", gain, 1'b1);
      cmd(16'h2300);
      check("unmapped", rd, 8'h00);
   endtask

   task automatic t_cfg_fields();
      logic [7:0] tbl [6] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'hC0, 8'h00};
      cmd(16'h1040);
      cmd(16'h1100);
      cmd(16'h1000);
      check("manual gain", gain, 1'b0);
      foreach (tbl[i])
      begin
         cmd({8'h11, tbl[i]});
         check("outs", {gain, lcal, ps_hi, ps_lo, drx, cont, hold, ftrk, atrk},
               exp_outs(tbl[i], 8'h00));
         cmd(16'h2100);
         check("cfg", rd & 8'h7F, tbl[i] & 8'h7F);
      end
   endtask

   task automatic t_ctl_fields();
      oe_cy = 0;
      cmd(16'h12FC);
      check("oe write", oe_cy == 0, 1'b1);
      check("outs", {gain, lcal, ps_hi, ps_lo, drx, cont, hold, ftrk, atrk},
            exp_outs(8'h00, 8'h4C));
      cmd(16'h2200);
      check("ctl", rd & 8'h4F, 8'h4C);
      cmd(16'h1200);
   endtask

   task automatic t_power_up();
      cmd(16'h3000);
      cmd(16'h10FE);
      cmd(16'h135F);
      cmd(16'h1120);
      check("lcal", lcal, 1'b1);
      run_cy = 0;
      cmd(16'h1201);
      check("fcr", fcr, 1'b1);
      cmd(16'h2900);
      check("busy sts", rd, 8'h00);
      wait_cal(1000);
      check("long len", (run_cy >= LONG_CY && run_cy <= LONG_CY + 2), 1'b1);
      cmd(16'h2900);
      check("done sts", rd, 8'h01);
      check("flag", fdone, 1'b1);
      cmd(16'h2200);
      check("ctl clr", rd & 8'h03, 8'h00);
   endtask

   task automatic t_short_and_abort();
      cmd(16'h1100);
      run_cy = 0;
      cmd(16'h1201);
      wait_cal(1000);
      check("short len", (run_cy >= SHORT_CY && run_cy <= SHORT_CY + 2), 1'b1);
      cmd(16'h1120);
      cmd(16'h1201);
      cmd(16'h3000);
      check("abort", {fcr, fdone}, 2'b00);
      check("outs", {gain, lcal, ps_hi, ps_lo, drx, cont, hold, ftrk, atrk},
            exp_outs(8'h40, 8'h00));
   endtask

   task automatic t_poll_cal();
      run_cy = 0;
      cmd(16'h1202);
      check("pcr", pcr, 1'b1);
      wait_cal(1000);
      check("poll len", (run_cy >= POLL_CY && run_cy <= POLL_CY + 2), 1'b1);
      cmd(16'h2200);
      check("ctl clr", rd & 8'h03, 8'h00);
      cmd(16'h2900);
      check("poll sts", rd & 8'h02, 8'h02);
   endtask

   task automatic t_pins();
      @(posedge clk) #1;
      freq_data_rx = 1'b1;
      ampl_data_rx = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("rx pins", {freq_data_pin, ampl_data_pin}, 2'b10);
      cmd(16'h1110);
      pin_sel = 2'd1;
      cmd(16'h2100);
      check("fpin rd", rd, 8'h10);
      pin_sel = 2'd0;
      cmd(16'h1108);
      pin_sel = 2'd2;
      cmd(16'h2100);
      check("apin rd", rd, 8'h08);
      pin_sel = 2'd0;
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      n_fail = 0;
      total_checks = 0;
      run_cy = 0;
      oe_cy = 0;
      pin_sel = 2'd0;
      srst = 1'b1;
      freq_data_rx = 1'b0;
      ampl_data_rx = 1'b1;
      repeat (10) @(posedge clk);
      #1 srst = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      t_reset_values();
      t_cfg_fields();
      t_ctl_fields();
      t_power_up();
      t_short_and_abort();
      t_poll_cal();
      t_pins();
      stop_test();
   end

   initial
   begin
      #500000;
      n_fail++;
      stop_test();
   end
endmodule // tb_rcr_regs
